// File: inc/tlih_pkg.sv
// Package: constants, registers and states of the two-level interrupt handler
// Functional notes
// - Source event sets its pending flag
// - Request needs flag, source enable, global enable
// - Finish instruction, then long call to vector
// - Return from service resumes interrupted flow
// - Flags set even when source disabled
// - Some flags auto-clear on vectoring; others software
// - Flag still set after return re-requests
// - Each source has own enable bit
// - Global enable bit 7 gates all sources
// - Events during global disable stay pending
// - Software flag set acts like real event
// - Per-source priority bit, default low
// - High preempts low; high never preempted
// - Higher level first, then fixed order
// - Requests sampled and resolved every cycle
// - Minimum latency seven cycles from request
// - Equal/lower waits for return plus one instruction
package tlih_pkg;
    // -------------------------------------------------------------------
    // Sizes
    // -------------------------------------------------------------------
    localparam int NSRC      = 19;
    localparam int SRC_W     = 5;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 8;
    localparam int VEC_W     = 16;
    // -------------------------------------------------------------------
    // Register offsets
    // -------------------------------------------------------------------
    localparam logic [7:0] ADR_IE0   = 8'hA8;
    localparam logic [7:0] ADR_IE1   = 8'hE6;
    localparam logic [7:0] ADR_IE2   = 8'hE7;
    localparam logic [7:0] ADR_IP0   = 8'hB8;
    localparam logic [7:0] ADR_IP1   = 8'hF6;
    localparam logic [7:0] ADR_IP2   = 8'hF7;
    localparam logic [7:0] ADR_PND0  = 8'hC4;
    localparam logic [7:0] ADR_PND1  = 8'hC5;
    localparam logic [7:0] ADR_PND2  = 8'hC6;
    localparam logic [7:0] ADR_STAT  = 8'hC3;
    localparam int          GIE_BIT  = 7;
    localparam logic [7:0] RST_REG   = 8'h00;
    localparam logic [NSRC-1:0] AUTO_CLR_MASK = 19'h0000F;
    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int CLK_NS      = 40;
    localparam int CALL_NS     = 200;
    localparam int CALL_CYC    = (CALL_NS + CLK_NS - 1) / CLK_NS;
    localparam int MIN_LAT_CYC = 7;
    localparam logic [2:0] CALL_CNT = 3'(CALL_CYC);
    localparam logic [VEC_W-1:0] VEC_BASE = 16'h0003;
    localparam logic [VEC_W-1:0] VEC_STEP = 16'h0008;
    typedef enum logic [2:0] {
        TLIH_IDLE  = 3'b000,
        TLIH_WAIT  = 3'b001,
        TLIH_CALL  = 3'b010,
        TLIH_HOLD  = 3'b011
    } tlih_state_t;
endpackage

// File: tb/test_two_level_interrupt_handler.sv
// Testbench for the two-level interrupt handler
`timescale 1ns/1ns
module test_two_level_interrupt_handler;
    import tlih_pkg::*;
    logic             clock, nrst, reg_wr, reg_rd, slow, ret_cmd;
    logic [7:0]       reg_addr, reg_wdata, reg_rdata, d;
    logic [NSRC-1:0]  src_event, pending, p;
    logic             instr_done, ret_done, irq_req, long_call;
    logic [VEC_W-1:0] vec_addr;
    int               err_count, total_checks;

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    tlih_ctrl u_dut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_event(src_event),
        .instr_done(instr_done), .ret_done(ret_done), .irq_req(irq_req),
        .long_call(long_call), .vec_addr(vec_addr), .pending(pending));
    tlih_cpu_model u_cpu (.clock(clock), .nrst(nrst), .long_call(long_call), .slow(slow),
        .ret_cmd(ret_cmd), .instr_done(instr_done), .ret_done(ret_done));

    // -------------------------------------------------------------------
    // Shared tasks
    // -------------------------------------------------------------------
    task summarize;
        if (err_count == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task hang(input int n, input string msg);
        if (n >= 40) begin
            err_count++;
            $display("BAD %0t timeout %s", $time, msg);
            summarize();
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clock);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task rd_pnd(output logic [NSRC-1:0] v);
        logic [7:0] a, b, c;
        rd(ADR_PND0, a); rd(ADR_PND1, b); rd(ADR_PND2, c);
        v = {c[2:0], b, a};
    endtask
    task set_en(input logic [NSRC-1:0] m, input logic g);
        wr(ADR_IE1, m[14:7]); wr(ADR_IE2, {4'h0, m[18:15]}); wr(ADR_IE0, {g, m[6:0]});
    endtask
    task set_pr(input logic [NSRC-1:0] m);
        wr(ADR_IP0, {1'b0, m[6:0]}); wr(ADR_IP1, m[14:7]); wr(ADR_IP2, {4'h0, m[18:15]});
    endtask
    task pulse(input logic [NSRC-1:0] m);
        @(posedge clock) src_event <= m;
        @(posedge clock) src_event <= '0;
    endtask
    task no_irq(input int n, input string msg);
        repeat (n) begin
            @(posedge clock);
            #1 chk(irq_req === 1'b0, msg);
        end
    endtask
    // Request, vector of the winner, then a call of fixed length
    task take(input int idx);
        int n;
        n = 0;
        #1;
        while (irq_req !== 1'b1 && n < 40) begin @(posedge clock); #1; n++; end
        hang(n, "request");
        chk(vec_addr === VEC_BASE + VEC_STEP * 16'(idx), "wrong vector");
        n = 0;
        while (long_call !== 1'b1 && n < 40) begin @(posedge clock); #1; n++; end
        hang(n, "call");
        n = 0;
        while (long_call === 1'b1 && n < 40) begin @(posedge clock); #1; n++; end
        chk(n == CALL_CYC, "call length");
    endtask
    task ret_isr;
        int n;
        @(posedge clock) ret_cmd <= 1'b1;
        @(posedge clock) ret_cmd <= 1'b0;
        n = 0;
        #1;
        while (ret_done !== 1'b1 && n < 40) begin @(posedge clock); #1; n++; end
        hang(n, "return");
    endtask

    // -------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------
    task s_reset;
        rd(ADR_IE0, d); chk(d === 8'h00, "enable reset");
        rd(ADR_IP1, d); chk(d === 8'h00, "priority not low");
        rd(8'h00, d); chk(d === 8'h00, "unmapped read");
    endtask
    task s_gate;
        set_en(19'h00000, 1'b1);
        pulse(19'h00020);
        no_irq(8, "disabled source");
        rd_pnd(p); chk(p === 19'h00020, "flag not set");
        chk(pending === 19'h00020, "pending port");
        set_en(19'h00020, 1'b0);
        no_irq(8, "global off");
        set_en(19'h00020, 1'b1);
        take(5);
        wr(ADR_PND0, 8'h00);
        ret_isr();
        no_irq(6, "after clear");
    endtask
    task s_auto;
        set_en(19'h00002, 1'b1);
        pulse(19'h00002);
        take(1);
        rd_pnd(p); chk(p[1] === 1'b0, "no auto clear");
        ret_isr();
    endtask
    task s_soft;
        @(posedge clock) slow <= 1'b1;
        set_en(19'h40000, 1'b1);
        wr(ADR_PND2, 8'h04);
        take(18);
        no_irq(8, "equal level nested");
        ret_isr();
        take(18);
        wr(ADR_PND2, 8'h00);
        ret_isr();
        no_irq(6, "after soft clear");
        @(posedge clock) slow <= 1'b0;
    endtask
    task s_prio;
        set_pr(19'h00600);
        set_en(19'h00640, 1'b1);
        pulse(19'h00240);
        take(9);
        wr(ADR_PND1, 8'h00);
        ret_isr();
        take(6);
        pulse(19'h00200);
        take(9);
        pulse(19'h00400);
        no_irq(8, "high preempted");
        rd(ADR_STAT, d); chk(d === 8'h06, "nesting status");
        wr(ADR_PND1, 8'h04);
        ret_isr();
        take(10);
        wr(ADR_PND1, 8'h00);
        ret_isr();
        wr(ADR_PND0, 8'h00);
        ret_isr();
        no_irq(6, "after nesting");
        set_pr(19'h00000);
        set_en(19'h01008, 1'b1);
        pulse(19'h01008);
        take(3);
        ret_isr();
        take(12);
        wr(ADR_PND1, 8'h00);
        ret_isr();
    endtask

    initial begin
        nrst = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
        src_event = '0; slow = 1'b0; ret_cmd = 1'b0;
        err_count = 0; total_checks = 0;
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        s_reset();
        s_gate();
        s_auto();
        s_soft();
        s_prio();
        summarize();
    end
endmodule // test_two_level_interrupt_handler

// File: tb/tlih_cpu_model.sv
// CPU core model: instruction boundaries, return from service, busy during the call
`timescale 1ns/1ns
module tlih_cpu_model (
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic long_call,
    input  wire logic slow,
    input  wire logic ret_cmd,
    output logic      instr_done,
    output logic      ret_done
);
    import tlih_pkg::*;
    // -------------------------------------------------------------------
    // Instruction stream
    // -------------------------------------------------------------------
    logic [1:0] cnt;
    logic       ret_want;

    // Vector slots always hold a valid routine here
    always_ff @(posedge clock) begin
        if (!nrst) begin
            cnt        <= 2'h0;
            ret_want   <= 1'b0;
            instr_done <= 1'b0;
            ret_done   <= 1'b0;
        end else begin
            instr_done <= 1'b0;
            ret_done   <= 1'b0;
            if (ret_cmd) begin
                ret_want <= 1'b1;
            end
            // No boundary while the core performs the call
            if (long_call) begin
                cnt <= 2'h0;
            end else if (cnt >= (slow ? 2'h2 : 2'h0)) begin
                cnt <= 2'h0;
                // Return is an instruction of its own; the next one follows it
                if (ret_want || ret_cmd) begin
                    ret_done <= 1'b1;
                    ret_want <= 1'b0;
                end else begin
                    instr_done <= 1'b1;
                end
            end else begin
                cnt <= cnt + 2'h1;
            end
        end
    end
endmodule // tlih_cpu_model

// File: verilog/tlih_arb.sv
// Module: priority arbiter over the gated pending sources
`timescale 1ns/1ns
module tlih_arb (
    input  wire logic [tlih_pkg::NSRC-1:0]   req,
    input  wire logic [tlih_pkg::NSRC-1:0]   prio,
    input  wire logic                        allow_low,
    input  wire logic                        allow_high,
    output logic                             any,
    output logic                             win_high,
    output logic [tlih_pkg::SRC_W-1:0]       win_idx
);
    import tlih_pkg::*;
    logic [NSRC-1:0] hi_req;
    logic [NSRC-1:0] lo_req;
    // Lowest index wins within a level
    function automatic logic [SRC_W-1:0] first_set(input logic [NSRC-1:0] v);
        logic [SRC_W-1:0] r;
        r = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = SRC_W'(i);
            end
        end
        return r;
    endfunction
    always_comb begin
        hi_req   = allow_high ? (req & prio) : '0;
        lo_req   = allow_low ? (req & ~prio) : '0;
        any      = |hi_req || |lo_req;
        win_high = |hi_req;
        win_idx  = |hi_req ? first_set(hi_req) : first_set(lo_req);
    end
endmodule // tlih_arb

// File: verilog/tlih_ctrl.sv
// Module: two-level interrupt handler control, registers and CPU handshake
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ns
module tlih_ctrl (
    input  wire logic                        clock,
    input  wire logic                        nrst,
    input  wire logic [tlih_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [tlih_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic [tlih_pkg::DATA_W-1:0]      reg_rdata,
    input  wire logic [tlih_pkg::NSRC-1:0]   src_event,
    input  wire logic                        instr_done,
    input  wire logic                        ret_done,
    output logic                             irq_req,
    output logic                             long_call,
    output logic [tlih_pkg::VEC_W-1:0]       vec_addr,
    output logic [tlih_pkg::NSRC-1:0]        pending
);
    import tlih_pkg::*;
    // -------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------
    logic [NSRC-1:0]   en;
    logic [NSRC-1:0]   prio;
    logic [NSRC-1:0]   clr_sw;
    logic [NSRC-1:0]   set_sw;
    logic [NSRC-1:0]   clr_hw;
    logic              in_low;
    logic              in_high;
    logic              block_one;
    tlih_state_t       state;
    logic [2:0]        call_cnt;
    logic [SRC_W-1:0]  sel;
    logic              sel_high;
    logic              any;
    logic              win_high;
    logic [SRC_W-1:0]  win_idx;
    logic              gie;
    // Write a byte lane of a 19-bit vector
    function automatic logic [NSRC-1:0] lane_wr(input logic [NSRC-1:0] v,
            input logic [1:0] lane, input logic [7:0] d);
        logic [23:0] t;
        t = {5'h00, v};
        t[lane*8 +: 8] = d;
        return t[NSRC-1:0];
    endfunction
    function automatic logic [7:0] lane_rd(input logic [NSRC-1:0] v, input logic [1:0] lane);
        logic [23:0] t;
        t = {5'h00, v};
        return t[lane*8 +: 8];
    endfunction
    // -------------------------------------------------------------------
    // Enable and priority registers
    // -------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!nrst) begin
            gie  <= RST_REG[GIE_BIT];
            en   <= '0;
            prio <= '0;
        end else if (reg_wr) begin
            // Bit 7 of the first byte is the global gate, so sources pack
            // seven, eight and four to the three bytes
            if (reg_addr == ADR_IE0) begin
                gie       <= reg_wdata[GIE_BIT];
                en[6:0]   <= reg_wdata[6:0];
            end else if (reg_addr == ADR_IE1) begin
                en[14:7]  <= reg_wdata;
            end else if (reg_addr == ADR_IE2) begin
                en[18:15] <= reg_wdata[3:0];
            end else if (reg_addr == ADR_IP0) begin
                prio[6:0]   <= reg_wdata[6:0];
            end else if (reg_addr == ADR_IP1) begin
                prio[14:7]  <= reg_wdata;
            end else if (reg_addr == ADR_IP2) begin
                prio[18:15] <= reg_wdata[3:0];
            end
        end
    end
    // -------------------------------------------------------------------
    // Pending flags
    // -------------------------------------------------------------------
    always_comb begin
        clr_sw = '0;
        set_sw = '0;
        if (reg_wr) begin
            if (reg_addr == ADR_PND0) begin
                clr_sw = ~lane_wr('0, 2'd0, reg_wdata) & lane_wr('1, 2'd0, 8'hFF) & 19'h000FF;
                set_sw = lane_wr('0, 2'd0, reg_wdata);
            end else if (reg_addr == ADR_PND1) begin
                clr_sw = ~lane_wr('0, 2'd1, reg_wdata) & 19'h0FF00;
                set_sw = lane_wr('0, 2'd1, reg_wdata);
            end else if (reg_addr == ADR_PND2) begin
                clr_sw = ~lane_wr('0, 2'd2, reg_wdata) & 19'h70000;
                set_sw = lane_wr('0, 2'd2, reg_wdata);
            end
        end
        clr_hw = '0;
        if (state == TLIH_WAIT && instr_done) begin
            clr_hw[sel] = AUTO_CLR_MASK[sel];
        end
    end
    // Hardware events win over any clear in the same cycle
    always_ff @(posedge clock) begin
        if (!nrst) begin
            pending <= '0;
        end else begin
            pending <= (pending & ~clr_sw & ~clr_hw) | set_sw | src_event;
        end
    end
    // -------------------------------------------------------------------
    // Arbitration
    // -------------------------------------------------------------------
    // Low requests need no routine running; high need no high routine; neither is taken in the cycle of a return or before the next instruction
    tlih_arb u_arb (
        .req        (pending & en & {NSRC{gie}}),
        .prio       (prio),
        .allow_low  (!in_low && !in_high && !block_one && !ret_done),
        .allow_high (!in_high && !block_one && !ret_done),
        .any        (any),
        .win_high   (win_high),
        .win_idx    (win_idx)
    );
    // -------------------------------------------------------------------
    // Request sequence
    // -------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!nrst) begin
            state    <= TLIH_IDLE;
            call_cnt <= 3'h0;
            sel      <= '0;
            sel_high <= 1'b0;
            irq_req  <= 1'b0;
            vec_addr <= 16'h0000;
        end else begin
            case (state)
                TLIH_IDLE: begin
                    if (any) begin
                        sel      <= win_idx;
                        sel_high <= win_high;
                        irq_req  <= 1'b1;
                        vec_addr <= VEC_BASE + VEC_STEP * VEC_W'(win_idx);
                        state    <= TLIH_WAIT;
                    end
                end
                TLIH_WAIT: begin
                    if (instr_done) begin
                        irq_req  <= 1'b0;
                        call_cnt <= CALL_CNT;
                        state    <= TLIH_CALL;
                    end
                end
                TLIH_CALL: begin
                    call_cnt <= call_cnt - 3'h1;
                    if (call_cnt == 3'h1) begin
                        state <= TLIH_IDLE;
                    end
                end
                default: begin
                    state <= TLIH_IDLE;
                end
            endcase
        end
    end
    assign long_call = (state == TLIH_CALL);
    // -------------------------------------------------------------------
    // Service nesting
    // -------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!nrst) begin
            in_low    <= 1'b0;
            in_high   <= 1'b0;
            block_one <= 1'b0;
        end else begin
            if (state == TLIH_WAIT && instr_done) begin
                if (sel_high) begin
                    in_high <= 1'b1;
                end else begin
                    in_low <= 1'b1;
                end
            end else if (ret_done) begin
                // Return closes the innermost routine first
                if (in_high) begin
                    in_high <= 1'b0;
                end else begin
                    in_low <= 1'b0;
                end
            end
            if (ret_done) begin
                block_one <= 1'b1;
            end else if (instr_done) begin
                block_one <= 1'b0;
            end
        end
    end
    // -------------------------------------------------------------------
    // Read port
    // -------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == ADR_IE0) begin
                reg_rdata <= {gie, en[6:0]};
            end else if (reg_addr == ADR_IE1) begin
                reg_rdata <= en[14:7];
            end else if (reg_addr == ADR_IE2) begin
                reg_rdata <= {4'h0, en[18:15]};
            end else if (reg_addr == ADR_IP0) begin
                reg_rdata <= {1'b0, prio[6:0]};
            end else if (reg_addr == ADR_IP1) begin
                reg_rdata <= prio[14:7];
            end else if (reg_addr == ADR_IP2) begin
                reg_rdata <= {4'h0, prio[18:15]};
            end else if (reg_addr == ADR_PND0) begin
                reg_rdata <= lane_rd(pending, 2'd0);
            end else if (reg_addr == ADR_PND1) begin
                reg_rdata <= lane_rd(pending, 2'd1);
            end else if (reg_addr == ADR_PND2) begin
                reg_rdata <= lane_rd(pending, 2'd2);
            end else if (reg_addr == ADR_STAT) begin
                reg_rdata <= {4'h0, block_one, in_high, in_low, irq_req};
            end else begin
                reg_rdata <= 8'h00;
            end
        end else begin
            reg_rdata <= 8'h00;
        end
    end
    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    sequence s_accept;
        state == TLIH_WAIT && instr_done;
    endsequence
    sequence s_call;
        long_call [*5];
    endsequence
    a_call_length: assert property (@(posedge clock) disable iff (!nrst)
        s_accept |=> s_call ##1 !long_call)
        else $error("long call not five cycles");
    a_event_sets: assert property (@(posedge clock) disable iff (!nrst)
        src_event[0] |=> pending[0])
        else $error("event did not set flag");
    a_gie_blocks: assert property (@(posedge clock) disable iff (!nrst)
        (state == TLIH_IDLE && !gie) |=> state == TLIH_IDLE)
        else $error("request while globally disabled");
    a_req_cause: assert property (@(posedge clock) disable iff (!nrst)
        $rose(irq_req) |-> ((($past(pending & en) >> sel) & 19'h00001) != 19'h00000))
        else $error("request without cause");
    a_req_enabled: assert property (@(posedge clock) disable iff (!nrst)
        $rose(irq_req) |-> $past(gie) && $past(|(pending & en)))
        else $error("request without enabled flag");
    a_high_nopreempt: assert property (@(posedge clock) disable iff (!nrst)
        (in_high && state == TLIH_IDLE) |=> !irq_req)
        else $error("high routine preempted");
    a_one_instr: assert property (@(posedge clock) disable iff (!nrst)
        ret_done |=> !$rose(irq_req))
        else $error("request right after return");
    a_prio_reset: assert property (@(posedge clock)
        !nrst |=> prio == '0)
        else $error("priority not low after reset");
    a_vector_map: assert property (@(posedge clock) disable iff (!nrst)
        state == TLIH_WAIT |-> vec_addr == VEC_BASE + VEC_STEP * VEC_W'(sel))
        else $error("vector address mismatch");
endmodule // tlih_ctrl
